/* pkg/supply_supervisor_defines.vh */
// register map, field positions and timing constants for the supply supervisor control
// assumes a 250 MHz system clock and APB register access
`ifndef SUPPLY_SUPERVISOR_DEFINES_VH
`define SUPPLY_SUPERVISOR_DEFINES_VH

// clock rate in MHz
`define CLOCK_MHZ            250
// times in ns as printed
`define SLOW_DELAY_NS        150000
`define FAST_DELAY_NS        2000
`define OVERSHOOT_NS         6000
// cycle counts derived from times; least times rounded up
`define SLOW_DELAY_CYC       ((`SLOW_DELAY_NS * `CLOCK_MHZ + 999) / 1000)
`define FAST_DELAY_CYC       ((`FAST_DELAY_NS * `CLOCK_MHZ + 999) / 1000)
`define OVERSHOOT_CYC        ((`OVERSHOOT_NS * `CLOCK_MHZ + 999) / 1000)
`define CNT_W                16

// register byte addresses
`define ADDR_LOW_CTRL        12'h000
`define ADDR_HIGH_CTRL       12'h004
`define ADDR_FLAGS           12'h008
`define ADDR_MODE            12'h00C
`define ADDR_STATE           12'h010
// unlock and prolong offsets are word indexes; byte address is four times the index
`define IDX_UNLOCK           10'h110
`define IDX_PROLONG          10'h112
`define ADDR_UNLOCK          ({`IDX_UNLOCK, 2'b00})
`define ADDR_PROLONG         ({`IDX_PROLONG, 2'b00})
`define ADDR_W               12

// side control fields
`define F_SUP_EN             0
`define F_SUP_KEEP           1
`define F_SUP_FP             2
`define F_MON_EN             3
`define F_MON_FP             4
`define F_AUTO               5
`define CTRL_W               6
`define CTRL_RESET           6'h01

// flags register fields
`define F_LOW_SETTLE         0
`define F_HIGH_SETTLE        1
`define F_HOLD               2
`define F_OVERSHOOT          3
`define F_HUNG               4

// mode register fields
`define F_DEEP_REQ           0

// unlock key and prolong enable mask
`define UNLOCK_KEY           16'h9602
`define PROLONG_MASK         16'h0800

// supervisor state encoding
`define ST_OFF               2'h0
`define ST_NORMAL            2'h1
`define ST_FULL              2'h2

`endif

/* core/side_state_decode.v */
// decodes one supply side's control bits into its awake and deep sleep states
// assumes plain control bits from the register file; purely combinational
`timescale 1ns/1ps
`include "supply_supervisor_defines.vh"

module side_state_decode (
  // control bits
  input  wire [5:0] i_ctrl,
  input  wire       i_deep_sleep,
  // decoded states
  output reg  [1:0] o_sup_state,
  output reg  [1:0] o_mon_state
);

  reg [1:0] awake_sup;
  reg [1:0] awake_mon;

  // awake state from enable and full performance, then deep sleep override
  always @* begin
    awake_sup = i_ctrl[`F_SUP_EN] ? (i_ctrl[`F_SUP_FP] ? `ST_FULL : `ST_NORMAL) : `ST_OFF;
    awake_mon = i_ctrl[`F_MON_EN] ? (i_ctrl[`F_MON_FP] ? `ST_FULL : `ST_NORMAL) : `ST_OFF;
    o_sup_state = awake_sup;
    o_mon_state = awake_mon;
    if (i_deep_sleep) begin
      if (!i_ctrl[`F_AUTO]) begin
        // manual: supervisor kept only with keep bit, monitor always kept
        o_sup_state = i_ctrl[`F_SUP_KEEP] ? awake_sup : `ST_OFF;
        o_mon_state = awake_mon;
      end else begin
        // automatic: kept full performance supervisor and full performance monitor drop to normal, all else off
        o_sup_state = (i_ctrl[`F_SUP_EN] && i_ctrl[`F_SUP_KEEP] && i_ctrl[`F_SUP_FP]) ?
                      `ST_NORMAL : `ST_OFF;
        o_mon_state = (awake_mon == `ST_FULL) ? `ST_NORMAL : `ST_OFF;
      end
    end
  end

endmodule

/* core/supply_supervisor_lowpower_control.v */
// supply supervisor and monitor control with wake-up hold-off and settling flags
// assumes an APB master on the system clock; comparators and regulator are outside
//
// How it works
// - slow wake hold-off 150 us in normal mode
// - fast 2 us hold-off when off or full
// - oscillator may overshoot 6 us after deep exit
// - sub-system clock never gated by hold-off
// - full performance settling delay about 2 us
// - normal mode settling delay about 150 us
// - low supervisor awake state from enable, full
// - manual deep sleep keeps state if keep bit
// - automatic deep sleep off except all-ones normal
// - slow wake only for normal low supervisor or low monitor
// - low monitor deep states per manual or automatic
// - high supervisor follows low side manual rules
// - high automatic deep sleep off except all-ones
// - high monitor deep states per manual, automatic
// - unlock key then mask enables prolongation; brownout clears
// - program reset, external reset clear hung state
`timescale 1ns/1ps
`include "supply_supervisor_defines.vh"

module supply_supervisor_lowpower_control (
  // clock and resets
  input  wire        i_clock,
  input  wire        i_reset_n,
  input  wire        i_brownout_reset,
  input  wire        i_program_unexpected_reset,
  input  wire        i_external_reset,
  // apb slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  input  wire [3:0]  i_pstrb,
  output wire        o_pready,
  output reg  [31:0] o_prdata,
  output reg         o_pslverr,
  // power mode events
  input  wire        i_wake_event,
  // supervisor states to analogue
  output wire [1:0]  o_low_sup_state,
  output wire [1:0]  o_low_mon_state,
  output wire [1:0]  o_high_sup_state,
  output wire [1:0]  o_high_mon_state,
  // clock and execution gating
  output reg         o_exec_hold,
  output wire        o_main_clock_enable,
  output wire        o_sub_clock_enable,
  output reg         o_osc_overshoot,
  output reg         o_prolong_enable
);

  reg  [`CTRL_W-1:0] low_side_ctrl_reg;
  reg  [`CTRL_W-1:0] high_side_ctrl_reg;
  reg                deep_sleep;
  reg                low_settle_flag;
  reg                high_settle_flag;
  reg  [`CNT_W-1:0]  low_settle_cnt;
  reg  [`CNT_W-1:0]  high_settle_cnt;
  reg  [`CNT_W-1:0]  hold_cnt;
  reg  [`CNT_W-1:0]  over_cnt;
  reg                unlocked;
  reg                hung;
  reg  [15:0]        unlock_word;
  reg  [2:0]         ext_sync;
  reg  [1:0]         wake_sync;
  reg  [1:0]         puc_sync;
  reg  [1:0]         bor_sync;
  wire               wake_level;
  wire               wake_rise;
  wire               ext_rise;
  wire               puc_level;
  wire               bor_level;
  wire               wr;
  wire               rd;
  wire               low_slow;
  wire               high_slow;
  wire               wake_slow;
  wire [`CNT_W-1:0]  slow_cyc;
  wire [`CNT_W-1:0]  fast_cyc;
  wire [`CNT_W-1:0]  over_cyc;
  reg  [31:0]        next_prdata;
  reg                next_pslverr;

  // counts worked out at 32 bits, then cut on purpose to the counter width
  wire [31:0]        slow_cyc_full = `SLOW_DELAY_CYC;
  wire [31:0]        fast_cyc_full = `FAST_DELAY_CYC;
  wire [31:0]        over_cyc_full = `OVERSHOOT_CYC;

  assign slow_cyc = slow_cyc_full[`CNT_W-1:0];
  assign fast_cyc = fast_cyc_full[`CNT_W-1:0];
  assign over_cyc = over_cyc_full[`CNT_W-1:0];

  // pin inputs pass two flops before use
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wake_sync <= 2'h0;
      puc_sync  <= 2'h0;
      bor_sync  <= 2'h0;
      ext_sync  <= 3'h0;
    end else begin
      wake_sync <= {wake_sync[0], i_wake_event};
      puc_sync  <= {puc_sync[0], i_program_unexpected_reset};
      bor_sync  <= {bor_sync[0], i_brownout_reset};
      ext_sync  <= {ext_sync[1:0], i_external_reset};
    end
  end

  assign wake_level = wake_sync[1];
  assign puc_level  = puc_sync[1];
  assign bor_level  = bor_sync[1];
  assign ext_rise   = ext_sync[1] & ~ext_sync[2];

  // synchronised wake level taken only while in deep sleep
  assign wake_rise = wake_level & deep_sleep;

  // apb decode; always zero wait states
  assign o_pready = 1'b1;
  assign wr = i_psel & i_penable & i_pwrite;
  assign rd = i_psel & ~i_penable & ~i_pwrite;

  // per-side state decode
  side_state_decode u_low (
    .i_ctrl       (low_side_ctrl_reg),
    .i_deep_sleep (deep_sleep),
    .o_sup_state  (o_low_sup_state),
    .o_mon_state  (o_low_mon_state)
  );

  side_state_decode u_high (
    .i_ctrl       (high_side_ctrl_reg),
    .i_deep_sleep (deep_sleep),
    .o_sup_state  (o_high_sup_state),
    .o_mon_state  (o_high_mon_state)
  );

  // settle speed: normal-mode supervisor means slow
  assign low_slow  = low_side_ctrl_reg[`F_SUP_EN] & ~low_side_ctrl_reg[`F_SUP_FP];
  assign high_slow = high_side_ctrl_reg[`F_SUP_EN] & ~high_side_ctrl_reg[`F_SUP_FP];
  // slow wake when the low supervisor or low monitor is in normal mode
  assign wake_slow = low_slow |
                     (low_side_ctrl_reg[`F_MON_EN] & ~low_side_ctrl_reg[`F_MON_FP]);

  // clock gating: sub clock free running, main clock held with execution
  assign o_sub_clock_enable  = 1'b1;
  assign o_main_clock_enable = ~o_exec_hold;

  // control registers and deep sleep request
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_side_ctrl_reg  <= `CTRL_RESET;
      high_side_ctrl_reg <= `CTRL_RESET;
      deep_sleep         <= 1'b0;
    end else begin
      if (wr && i_paddr == `ADDR_LOW_CTRL && i_pstrb[0])
        low_side_ctrl_reg <= i_pwdata[`CTRL_W-1:0];
      if (wr && i_paddr == `ADDR_HIGH_CTRL && i_pstrb[0])
        high_side_ctrl_reg <= i_pwdata[`CTRL_W-1:0];
      // wake wins over a fresh sleep request in the same cycle
      if (wake_rise || puc_level || ext_rise)
        deep_sleep <= 1'b0;
      else if (wr && i_paddr == `ADDR_MODE && i_pstrb[0] && i_pwdata[`F_DEEP_REQ])
        deep_sleep <= 1'b1;
    end
  end

  // settling delays, restarted by each write to a control register
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_settle_flag  <= 1'b0;
      high_settle_flag <= 1'b0;
      low_settle_cnt   <= {`CNT_W{1'b0}};
      high_settle_cnt  <= {`CNT_W{1'b0}};
    end else begin
      if (wr && i_paddr == `ADDR_LOW_CTRL && i_pstrb[0]) begin
        low_settle_flag <= 1'b1;
        low_settle_cnt  <= (i_pwdata[`F_SUP_EN] && !i_pwdata[`F_SUP_FP]) ?
                           slow_cyc : fast_cyc;
      end else if (low_settle_flag) begin
        if (low_settle_cnt <= 16'h0001)
          low_settle_flag <= 1'b0;
        low_settle_cnt <= low_settle_cnt - 16'h0001;
      end
      if (wr && i_paddr == `ADDR_HIGH_CTRL && i_pstrb[0]) begin
        high_settle_flag <= 1'b1;
        high_settle_cnt  <= (i_pwdata[`F_SUP_EN] && !i_pwdata[`F_SUP_FP]) ?
                            slow_cyc : fast_cyc;
      end else if (high_settle_flag) begin
        if (high_settle_cnt <= 16'h0001)
          high_settle_flag <= 1'b0;
        high_settle_cnt <= high_settle_cnt - 16'h0001;
      end
    end
  end

  // wake-up hold-off and oscillator overshoot window
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_exec_hold     <= 1'b0;
      o_osc_overshoot <= 1'b0;
      hold_cnt        <= {`CNT_W{1'b0}};
      over_cnt        <= {`CNT_W{1'b0}};
    end else begin
      if (wake_rise) begin
        o_exec_hold     <= 1'b1;
        hold_cnt        <= wake_slow ? slow_cyc : fast_cyc;
        o_osc_overshoot <= 1'b1;
        over_cnt        <= over_cyc;
      end else begin
        // release without software once the count runs out
        if (o_exec_hold) begin
          if (hold_cnt <= 16'h0001)
            o_exec_hold <= 1'b0;
          hold_cnt <= hold_cnt - 16'h0001;
        end
        if (o_osc_overshoot) begin
          if (over_cnt <= 16'h0001)
            o_osc_overshoot <= 1'b0;
          over_cnt <= over_cnt - 16'h0001;
        end
      end
    end
  end

  // hung flag: sleep entered while settling; cleared by program and external resets
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hung <= 1'b0;
    end else if (puc_level || ext_rise) begin
      hung <= 1'b0;
    end else if (wr && i_paddr == `ADDR_MODE && i_pstrb[0] && i_pwdata[`F_DEEP_REQ] &&
                 (low_settle_flag || high_settle_flag)) begin
      hung <= 1'b1; // a limitation kept visible: software ignored the settle flags
    end
  end

  // prolongation unlock sequence; brown-out clears it
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      unlock_word      <= 16'h0000;
      unlocked         <= 1'b0;
      o_prolong_enable <= 1'b0;
    end else if (bor_level) begin
      unlock_word      <= 16'h0000;
      unlocked         <= 1'b0;
      o_prolong_enable <= 1'b0;
    end else if (wr && i_paddr == `ADDR_UNLOCK) begin
      unlock_word <= i_pwdata[15:0];
      unlocked    <= (i_pwdata[15:0] == `UNLOCK_KEY);
    end else if (wr && i_paddr == `ADDR_PROLONG && unlocked &&
                 (i_pwdata[15:0] & `PROLONG_MASK) != 16'h0000) begin
      o_prolong_enable <= 1'b1;
    end
  end

  // read mux; unmapped addresses answer with an error
  always @* begin
    next_prdata  = 32'h00000000;
    next_pslverr = 1'b0;
    case (i_paddr)
      `ADDR_LOW_CTRL:        next_prdata = {26'h0, low_side_ctrl_reg};
      `ADDR_HIGH_CTRL:       next_prdata = {26'h0, high_side_ctrl_reg};
      `ADDR_FLAGS:           next_prdata = {27'h0, hung, o_osc_overshoot, o_exec_hold,
                                            high_settle_flag, low_settle_flag};
      `ADDR_MODE:            next_prdata = {31'h0, deep_sleep};
      `ADDR_STATE:           next_prdata = {24'h0, o_high_mon_state, o_high_sup_state,
                                            o_low_mon_state, o_low_sup_state};
      `ADDR_UNLOCK:          next_prdata = {16'h0, unlock_word};
      `ADDR_PROLONG:         next_prdata = {20'h0, o_prolong_enable, 11'h0};
      default:               next_pslverr = 1'b1;
    endcase
  end

  // read data and error registered in the setup cycle
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_prdata  <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else if (i_psel && !i_penable) begin
      o_prdata  <= rd ? next_prdata : 32'h00000000;
      o_pslverr <= next_pslverr;
    end
  end

endmodule

/* dv/supply_supervisor_lowpower_control_checker.sv */
// port checker for the supply supervisor control block
// assumes bind onto the top module; one clock domain, async low reset
`timescale 1ns/1ps

module supply_supervisor_lowpower_control_checker (
  // clock and resets
  input wire        i_clock,
  input wire        i_reset_n,
  input wire        i_brownout_reset,
  // apb
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire        o_pready,
  input wire        o_pslverr,
  // wake and gating
  input wire        i_wake_event,
  input wire        o_exec_hold,
  input wire        o_main_clock_enable,
  input wire        o_sub_clock_enable,
  input wire        o_osc_overshoot,
  input wire        o_prolong_enable
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  reg [15:0] hold_cnt;
  reg [15:0] over_cnt;
  // run lengths of the hold and overshoot windows
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hold_cnt <= 16'h0000;
      over_cnt <= 16'h0000;
    end else begin
      hold_cnt <= o_exec_hold ? hold_cnt + 16'h0001 : 16'h0000;
      over_cnt <= o_osc_overshoot ? over_cnt + 16'h0001 : 16'h0000;
    end
  end
  // brownout must be seen by both sync stages before it acts
  sequence s_brownout_pulse;
    i_brownout_reset [*3];
  endsequence
  a_pready_high: assert property (o_pready) else $error("pready low");
  a_main_gated: assert property (o_main_clock_enable == !o_exec_hold)
    else $error("main clock not gated by hold");
  a_sub_free: assert property (o_sub_clock_enable)
    else $error("sub clock gated");
  a_hold_cause: assert property ($rose(o_exec_hold) |-> $past(i_wake_event, 2))
    else $error("hold without wake");
  a_overshoot_start: assert property ($rose(o_exec_hold) |-> $rose(o_osc_overshoot))
    else $error("overshoot window not started");
  a_hold_length: assert property ($fell(o_exec_hold) |->
    (hold_cnt == 16'h01F4 || hold_cnt == 16'h927C))
    else $error("hold length wrong");
  a_overshoot_len: assert property ($fell(o_osc_overshoot) |-> over_cnt == 16'h05DC)
    else $error("overshoot length wrong");
  a_prolong_cause: assert property ($rose(o_prolong_enable) |->
    $past(i_psel && i_penable && i_pwrite && i_paddr == 12'h448 && i_pwdata[11]))
    else $error("prolong set without write");
  a_brownout_clear: assert property (s_brownout_pulse |-> ##[1:4] !o_prolong_enable)
    else $error("prolong survives brownout");
  a_unmapped_err: assert property (i_psel && !i_penable && i_paddr == 12'h020 |=> o_pslverr)
    else $error("no error on unmapped");
endmodule

bind supply_supervisor_lowpower_control supply_supervisor_lowpower_control_checker chk (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_brownout_reset(i_brownout_reset),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_wake_event(i_wake_event), .o_exec_hold(o_exec_hold),
  .o_main_clock_enable(o_main_clock_enable), .o_sub_clock_enable(o_sub_clock_enable),
  .o_osc_overshoot(o_osc_overshoot), .o_prolong_enable(o_prolong_enable));

/* dv/supply_supervisor_lowpower_control_test.sv */
// self-checking bench for the supply supervisor control block
// assumes the defines header on the include path and the bound checker
`timescale 1ns/1ps
`include "supply_supervisor_defines.vh"

module supply_supervisor_lowpower_control_test;
  reg         i_clock, i_reset_n, i_brownout_reset, i_program_unexpected_reset;
  reg         i_external_reset, i_psel, i_penable, i_pwrite, i_wake_event;
  reg  [11:0] i_paddr;
  reg  [31:0] i_pwdata;
  reg  [3:0]  i_pstrb;
  wire        o_pready, o_pslverr, o_exec_hold, o_main_clock_enable;
  wire        o_sub_clock_enable, o_osc_overshoot, o_prolong_enable;
  wire [31:0] o_prdata;
  wire [1:0]  o_low_sup_state, o_low_mon_state, o_high_sup_state, o_high_mon_state;
  integer     miscompares, checks_done, i;
  reg  [31:0] rd;
  reg         err;
  // low and high ctrl settings, all with fast settle and fast wake
  localparam [23:0] LO_T = {6'h25, 6'h07, 6'h3F, 6'h00};
  localparam [23:0] HI_T = {6'h3F, 6'h18, 6'h2D, 6'h0F};

  supply_supervisor_lowpower_control uut (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_brownout_reset(i_brownout_reset),
    .i_program_unexpected_reset(i_program_unexpected_reset),
    .i_external_reset(i_external_reset), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .i_wake_event(i_wake_event), .o_low_sup_state(o_low_sup_state),
    .o_low_mon_state(o_low_mon_state), .o_high_sup_state(o_high_sup_state),
    .o_high_mon_state(o_high_mon_state), .o_exec_hold(o_exec_hold),
    .o_main_clock_enable(o_main_clock_enable), .o_sub_clock_enable(o_sub_clock_enable),
    .o_osc_overshoot(o_osc_overshoot), .o_prolong_enable(o_prolong_enable));

  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  task final_report;
    begin
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task give_up;
    begin
      miscompares = miscompares + 1;
      $display("MISMATCH %0t wait ran out", $time);
      final_report;
    end
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // one apb transfer; holds the request until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    integer k;
    begin
      @(posedge i_clock);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clock);
      i_penable <= 1'b1;
      k = 0;
      @(posedge i_clock);
      while (o_pready !== 1'b1) begin
        if (k == 16) give_up;
        k = k + 1;
        @(posedge i_clock);
      end
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
    end
  endtask
  task wait_settle(input integer limit);
    integer k;
    begin
      k = 0;
      apb(1'b0, `ADDR_FLAGS, 32'h0);
      while (rd[1:0] !== 2'b00) begin
        if (k == limit) give_up;
        k = k + 1;
        apb(1'b0, `ADDR_FLAGS, 32'h0);
      end
    end
  endtask
  function [1:0] sup_st(input [5:0] c, input deep);
    if (!c[0]) sup_st = `ST_OFF;
    else if (!deep || (!c[5] && c[1])) sup_st = c[2] ? `ST_FULL : `ST_NORMAL;
    else if (c[5] && c[1] && c[2]) sup_st = `ST_NORMAL;
    else sup_st = `ST_OFF;
  endfunction
  function [1:0] mon_st(input [5:0] c, input deep);
    if (!c[3]) mon_st = `ST_OFF;
    else if (!deep || !c[5]) mon_st = c[4] ? `ST_FULL : `ST_NORMAL;
    else mon_st = c[4] ? `ST_NORMAL : `ST_OFF;
  endfunction
  // ports and state register against the decode table
  task states(input [5:0] lo, input [5:0] hi, input deep);
    reg [7:0] e;
    begin
      #1;
      e = {mon_st(hi, deep), sup_st(hi, deep), mon_st(lo, deep), sup_st(lo, deep)};
      check({o_high_mon_state, o_high_sup_state, o_low_mon_state, o_low_sup_state}, e);
      apb(1'b0, `ADDR_STATE, 32'h0);
      check(rd[7:0], e);
    end
  endtask
  // wake from deep sleep and time the hold-off to the cycle
  task wake(input logic [31:0] len);
    integer k;
    integer h;
    integer ov;
    begin
      i_wake_event <= 1'b1;
      k = 0;
      while (o_exec_hold !== 1'b1) begin
        if (k == 8) give_up;
        k = k + 1;
        @(posedge i_clock);
        #1;
      end
      check(o_main_clock_enable, 1'b0);
      check(o_sub_clock_enable, 1'b1);
      check(o_osc_overshoot, 1'b1);
      k = 0;
      h = 1;
      ov = 1;
      // both windows start together; wait for the longer one before the next access
      while ((o_exec_hold === 1'b1 || o_osc_overshoot === 1'b1) && k < 40000) begin
        @(posedge i_clock);
        #1;
        k = k + 1;
        h = h + o_exec_hold;
        ov = ov + o_osc_overshoot;
      end
      check(h, len);
      check(ov, `OVERSHOOT_CYC);
      @(posedge i_clock);
      i_wake_event <= 1'b0;
      apb(1'b0, `ADDR_MODE, 32'h0);
      check(rd[0], 1'b0);
    end
  endtask
  task pulse_reset(input [2:0] sel);
    begin
      @(posedge i_clock);
      {i_external_reset, i_program_unexpected_reset, i_brownout_reset} <= sel;
      repeat (4) @(posedge i_clock);
      {i_external_reset, i_program_unexpected_reset, i_brownout_reset} <= 3'h0;
      repeat (4) @(posedge i_clock);
    end
  endtask

  initial begin
    {i_reset_n, i_brownout_reset, i_program_unexpected_reset, i_external_reset} = 4'h0;
    {i_psel, i_penable, i_pwrite, i_wake_event} = 4'h0;
    i_paddr = 12'h000;
    i_pwdata = 32'h0;
    i_pstrb = 4'hF;
    miscompares = 0;
    checks_done = 0;
    repeat (10) @(posedge i_clock);
    i_reset_n <= 1'b1;
    // reset decode and an unmapped place
    states(6'h01, 6'h01, 1'b0);
    apb(1'b0, 12'h020, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h00000000);
    // a wake level while awake is ignored
    i_wake_event <= 1'b1;
    repeat (8) @(posedge i_clock);
    i_wake_event <= 1'b0;
    #1 check(o_exec_hold, 1'b0);
    // normal low supervisor: long settle, then slow wake
    apb(1'b1, `ADDR_LOW_CTRL, 32'h01);
    repeat (37400) @(posedge i_clock);
    apb(1'b0, `ADDR_FLAGS, 32'h0);
    check(rd[0], 1'b1);
    wait_settle(60);
    apb(1'b1, `ADDR_MODE, 32'h1);
    states(6'h01, 6'h01, 1'b1);
    wake(32'h927C);
    // decode table with fast settle and fast wake
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, `ADDR_LOW_CTRL, {26'h0, LO_T[i*6 +: 6]});
      apb(1'b1, `ADDR_HIGH_CTRL, {26'h0, HI_T[i*6 +: 6]});
      apb(1'b0, `ADDR_FLAGS, 32'h0);
      check(rd[1:0], 2'b11);
      states(LO_T[i*6 +: 6], HI_T[i*6 +: 6], 1'b0);
      repeat (400) @(posedge i_clock);
      apb(1'b0, `ADDR_FLAGS, 32'h0);
      check(rd[1:0], 2'b11);
      wait_settle(60);
      apb(1'b1, `ADDR_MODE, 32'h1);
      states(LO_T[i*6 +: 6], HI_T[i*6 +: 6], 1'b1);
      wake(32'h01F4);
    end
    // prolongation needs the key, brownout clears it and the key
    apb(1'b1, `ADDR_UNLOCK, {16'h0, `UNLOCK_KEY});
    apb(1'b1, `ADDR_PROLONG, {16'h0, `PROLONG_MASK});
    #1 check(o_prolong_enable, 1'b1);
    apb(1'b0, `ADDR_PROLONG, 32'h0);
    check(rd, {16'h0, `PROLONG_MASK});
    pulse_reset(3'h1);
    #1 check(o_prolong_enable, 1'b0);
    apb(1'b1, `ADDR_PROLONG, {16'h0, `PROLONG_MASK});
    #1 check(o_prolong_enable, 1'b0);
    // sleep during settle hangs; program reset, then external reset recover
    for (i = 1; i < 3; i = i + 1) begin
      apb(1'b1, `ADDR_LOW_CTRL, 32'h05);
      apb(1'b1, `ADDR_MODE, 32'h1);
      apb(1'b0, `ADDR_FLAGS, 32'h0);
      check(rd[4], 1'b1);
      pulse_reset(3'h1 << i);
      apb(1'b0, `ADDR_FLAGS, 32'h0);
      check(rd[4], 1'b0);
      apb(1'b0, `ADDR_MODE, 32'h0);
      check(rd[0], 1'b0);
    end
    final_report;
  end
endmodule
